/* File: dv/dasp_dev_model.sv */
/* Behavioural converter serial port with two setup registers.
   Assumes a host that clocks at most 44 bits in each frame. */
`timescale 1ns/10ps
module dasp_dev_model (
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic cmd_in,
   output logic out_a,
   output logic out_b
);
   // ------------------------------------------------------------
   // Device state
   // ------------------------------------------------------------
   logic [11:0] prim_r = '0;
   logic [11:0] sec_r = '0;
   logic [31:0] shift_r = '0;
   logic [15:0] cmd_r = '0;
   logic [15:0] conv_a_r = '0;
   logic [15:0] conv_b_r = '0;
   logic [15:0] rd_word_r = '0;
   logic rd_pend_r = 1'b0;
   int nbit = 0;
   int conv_n = 0;
   initial begin
      out_a = 1'b0;
      out_b = 1'b0;
   end
   // Frame start: hold, convert, show the first bit of the pending read word or of the last results
   always @(negedge cs_n) begin
      shift_r = rd_pend_r ? {rd_word_r, rd_word_r} : {conv_a_r, conv_b_r};
      conv_n++;
      conv_a_r = {4'hA, conv_n[11:0]};
      conv_b_r = {4'h5, ~conv_n[11:0]};
      nbit = 0;
      out_a = shift_r[31];
      out_b = sec_r[8] ? ~out_b : shift_r[15];
   end
   // Shift out on each rise, take command bits
   always @(posedge sclk) begin
      if (!cs_n) begin
         if (nbit < 16) cmd_r = {cmd_r[14:0], cmd_in};
         nbit++;
         shift_r = shift_r << 1;
         out_a = shift_r[31];
         out_b = sec_r[8] ? ~out_b : shift_r[15];
      end
   end
   // Frame end: invert both lines, act on the command
   always @(posedge cs_n) begin
      out_a = ~out_a;
      out_b = ~out_b;
      rd_pend_r = 1'b0;
      if (nbit >= 16 && cmd_r[15]) begin
         if (cmd_r[14:12] == 3'h1) prim_r = cmd_r[11:0];
         if (cmd_r[14:12] == 3'h2) begin
            if (cmd_r[7:0] == dasp_pkg::RESET_HARD) {prim_r, sec_r} = '0;
            else if (cmd_r[7:0] == dasp_pkg::RESET_SOFT) sec_r = {cmd_r[11:8], 8'h00};
            else sec_r = cmd_r[11:0];
         end
      end else if (nbit >= 16 && cmd_r[14:12] inside {3'h1, 3'h2}) begin
         rd_pend_r = 1'b1;
         rd_word_r = {1'b0, cmd_r[14:12], (cmd_r[14:12] == 3'h1) ? prim_r : sec_r};
      end
   end
endmodule : dasp_dev_model

/* File: dv/dasp_host_props.sv */
/* Checker for the serial host ports: bus answer timing and frame shape.
   Assumes it is bound to every dasp_host instance. */
`timescale 1ns/10ps
module dasp_host_props (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic serial_command_input,
   input wire logic first_serial_output,
   input wire logic second_output_or_limit_pin
);
   // ------------------------------------------------------------
   // Bus answer and frame checks
   // ------------------------------------------------------------
   logic sclk_q_r;
   logic [6:0] rise_r;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Count serial clock rises inside the frame
   always_ff @(posedge mclk) begin
      sclk_q_r <= sclk;
      rise_r <= (cs_n || !nrst) ? 7'h00 : rise_r + 7'(sclk && !sclk_q_r);
   end
   ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus answer late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus answer too long");
   idle_clock_a: assert property (cs_n |-> !sclk)
      else $error("serial clock moves outside frame");
   frame_end_a: assert property ($rose(cs_n) |-> !$past(sclk))
      else $error("frame closed before last fall");
   clock_count_a: assert property ($rose(cs_n) |-> rise_r >= 16 && rise_r <= 44)
      else $error("frame clock count out of range");
   frame_gap_a: assert property ($rose(cs_n) |-> cs_n [*2])
      else $error("frame gap too short");
   high_half_a: assert property ($rose(sclk) |=> sclk [*3] ##1 !sclk)
      else $error("serial clock high phase wrong");
   low_half_a: assert property ($fell(sclk) |=> !sclk [*3])
      else $error("serial clock low phase short");
   cmd_stable_a: assert property (!cs_n && $changed(serial_command_input) |-> !sclk)
      else $error("command bit changed while clock high");
   // Main scenarios seen
   cover property ($rose(cs_n) && rise_r == 7'h10);
   cover property ($rose(cs_n) && rise_r == 7'h20);
   cover property (wb_ack_o && wb_we_i);
endmodule : dasp_host_props

bind dasp_host dasp_host_props u_props (.mclk(mclk), .nrst(nrst), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cs_n(cs_n), .sclk(sclk),
   .serial_command_input(serial_command_input), .first_serial_output(first_serial_output),
   .second_output_or_limit_pin(second_output_or_limit_pin));

/* File: dv/tb_dasp_host.sv */
/* Bench for the serial host: orders over Wishbone, converter model behind.
   Assumes the model's result formula and the package offsets. */
`timescale 1ns/10ps
module tb_dasp_host;
   // ------------------------------------------------------------
   // Stimulus and checks
   // ------------------------------------------------------------
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic [31:0] adr = 32'h0000_0000;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] dat_o;
   logic [31:0] rdata;
   logic ack, cs_n, sclk, cmd_line, line_a, line_b;
   int fail_count = 0;
   int checked = 0;
   int nfall = 0;
   dasp_host dut (.mclk(mclk), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
      .cs_n(cs_n), .sclk(sclk), .serial_command_input(cmd_line),
      .first_serial_output(line_a), .second_output_or_limit_pin(line_b));
   dasp_dev_model u_dev (.cs_n(cs_n), .sclk(sclk), .cmd_in(cmd_line), .out_a(line_a),
      .out_b(line_b));
   // Clock and frame counter
   always #25 mclk = ~mclk;
   always @(negedge cs_n) nfall++;
   function automatic logic [15:0] fa(input int n);
      return {4'hA, n[11:0]};
   endfunction : fa
   function automatic logic [15:0] fb(input int n);
      return {4'h5, ~n[11:0]};
   endfunction : fb
   task automatic summarize;
      if (fail_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One classic Wishbone cycle, read data left in rdata
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      adr <= 32'(a);
      we <= w;
      dat <= d;
      cyc <= 1'b1;
      stb <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 100);
      rdata = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 100) begin
         fail_count++;
         summarize();
      end
      @(posedge mclk);
   endtask : wb
   // Start an order and wait until it is done
   task automatic run(input logic [15:0] word, input logic conv);
      int n;
      n = 0;
      wb(1'b1, dasp_pkg::OFS_CMD, {14'h0000, 1'b1, conv, word});
      while (cs_n !== 1'b0 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 50) begin
         fail_count++;
         summarize();
      end
      do begin
         wb(1'b0, dasp_pkg::OFS_STAT, 32'h0000_0000);
         n++;
      end while (rdata[0] !== 1'b0 && n < 600);
      if (n >= 600) begin
         fail_count++;
         summarize();
      end
   endtask : run
   task automatic chk_conv;
      wb(1'b0, dasp_pkg::OFS_RES_A, 32'h0000_0000);
      check(rdata, {16'h0000, fa(nfall - 1)});
      wb(1'b0, dasp_pkg::OFS_RES_B, 32'h0000_0000);
      check(rdata, {16'h0000, fb(nfall - 1)});
   endtask : chk_conv
   task automatic chk_reg(input logic [15:0] exp);
      run(16'h1000, 1'b0);
      wb(1'b0, dasp_pkg::OFS_RES_A, 32'h0000_0000);
      check(rdata, {16'h0000, exp});
   endtask : chk_reg
   // Back-to-back conversions on two lanes
   task automatic t_two_lane;
      run(dasp_pkg::NOP_WORD, 1'b1);
      chk_conv();
      run(dasp_pkg::NOP_WORD, 1'b1);
      chk_conv();
   endtask : t_two_lane
   // Write, soft reset keeps it, hard reset clears it
   task automatic t_resets;
      run(16'h9004, 1'b0);
      chk_reg(16'h1004);
      run(16'hA03C, 1'b0);
      chk_reg(16'h1004);
      run(16'hA0FF, 1'b0);
      chk_reg(16'h1000);
   endtask : t_resets
   // Read of an undefined address gives results
   task automatic t_undef;
      run(16'h7000, 1'b0);
      chk_conv();
   endtask : t_undef
   task automatic t_unmapped;
      wb(1'b0, 8'h40, 32'h0000_0000);
      check(rdata, 32'h0000_0000);
   endtask : t_unmapped
   // One lane with low latency: A then B on the first output
   task automatic t_one_lane;
      run(16'hA100, 1'b0);
      wb(1'b1, dasp_pkg::OFS_CTRL, 32'h0000_0021);
      run(dasp_pkg::NOP_WORD, 1'b1);
      chk_conv();
   endtask : t_one_lane
   // Main sequence
   initial begin
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      t_two_lane();
      t_resets();
      t_undef();
      t_unmapped();
      t_one_lane();
      summarize();
   end
endmodule : tb_dasp_host

/* File: verilog/dasp_crc.sv */
/*
 * Bit-serial checksum x^8 + x^2 + x + 1, first eight data bits inverted.
 * Assumes one bit per step, most significant bit first.
 */
`timescale 1ns/10ps
module dasp_crc (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clr,
   input wire logic step,
   input wire logic din,
   input wire logic [5:0] idx,
   output logic [7:0] crc
);
   logic fb;

   // Invert the first eight bits, then divide
   assign fb = crc[7] ^ din ^ (idx < 6'd8);
   always_ff @(posedge mclk) begin
      if (!nrst || clr) begin
         crc <= 8'h00;
      end else if (step) begin
         crc <= {crc[6:0], 1'b0} ^ (fb ? dasp_pkg::CRC_POLY : 8'h00);
      end
   end
endmodule : dasp_crc

/* File: verilog/dasp_host.sv */
/*
 * Host controller for a dual simultaneous-sampling converter serial port.
 * Software writes orders over classic Wishbone; the controller runs chip select
 * frames, shifts commands out and conversion or register data in.
 * Assumes the converter returns data as documented and the 20 MHz clock.
 */
// Local design decisions: the register offsets and the Wishbone slave port.
// Summary of operation
// RULE1: Reset is a write of a code into the secondary setup reset field.
// RULE2: Soft reset keeps configuration; device reinitialises its logic.
// RULE3: Hard reset also restores register defaults.
// RULE4: Device runs self test after power-on and hard reset.
// RULE5: Host issues hard reset when self-test fail flag reads set. The controller never reads this flag and leaves the reset to software.
// RULE6: Chip select falling edge starts conversion, enables outputs.
// RULE7: Register accesses get at least sixteen serial clocks.
// RULE8: Conversions timed by device oscillator, not serial clock.
// RULE9: Results arrive one frame after the conversion start.
// RULE10: Most significant bit first; bits change on rising clock edges.
// RULE11: Chip select rises after last falling clock edge.
// RULE12: Every access completes inside one chip select frame.
// RULE13: Two-lane reads take 16, plus 2 boost, plus 8 checksum.
// RULE14: One-lane reads double data clocks and add 8 for checksum.
// RULE15: Two-lane mode: A on first output, B on second.
// RULE16: One-lane mode: A then B on first output.
// RULE17: Boost widens each result by two bits.
// RULE18: Low-latency: second frame after conversion time returns result.
// RULE19: Read command: bit 15 clear, address in bits 14 to 12.
// RULE20: A read is followed by another frame that carries the data.
// RULE21: Write command: bit 15 set, address, twelve data bits.
// RULE22: Writes are 16 bits, 24 with write checksum.
// RULE23: Read and write checksums enable independently.
// RULE24: Read checksum of eight bits follows the data on first output.
// RULE25: Checksum x^8+x^2+x+1 with first eight bits inverted.
// RULE26: With write checksums, writes lacking a valid checksum are ignored.
// RULE27: Reads of undefined addresses return conversion results next frame.
`timescale 1ns/10ps
module dasp_host (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic cs_n,
   output logic sclk,
   output logic serial_command_input,
   input wire logic first_serial_output,
   input wire logic second_output_or_limit_pin
);

   // ------------------------------------------------------------------
   // Types and state
   // ------------------------------------------------------------------
   // S_END keeps the clock low for a half period before chip select rises
   // S_WAIT spaces a low-latency data frame by the conversion time
   typedef enum logic [2:0] {S_IDLE, S_LOW, S_HIGH, S_END, S_WAIT, S_GAP} dasp_state_t;
   dasp_state_t state_r, state_nxt;

   logic [5:0] ctrl_r;
   logic [17:0] cmd_r;
   logic busy_r;
   logic [2:0] seq_r;                   // Frames still to run in this order
   logic [5:0] bit_r;
   logic [5:0] nbits_r;
   logic [2:0] half_r;
   logic [7:0] conv_r;
   logic [23:0] tx_r;
   logic [43:0] rx_a_r;
   logic [17:0] rx_b_r;
   logic [17:0] res_a_r;
   logic [17:0] res_b_r;
   logic [7:0] crc_rx_r;
   logic crc_ok_r;
   logic ack_r;
   logic sdo_a, sdo_b;
   logic [7:0] crc_tx, crc_chk;
   dasp_pkg::dasp_req_t req;
   dasp_pkg::dasp_rsp_t rsp;

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   // Device lines are asynchronous to mclk
   dasp_sync u_sync_a (.mclk(mclk), .nrst(nrst), .d(first_serial_output), .q(sdo_a));
   dasp_sync u_sync_b (.mclk(mclk), .nrst(nrst), .d(second_output_or_limit_pin), .q(sdo_b));

   // ------------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------------
   // Bits per channel: 16, plus 2 with boost, minus 2 when narrow
   function automatic logic [5:0] data_bits(input logic boost, input logic narrow);
      data_bits = dasp_pkg::BITS_BASE + (boost ? dasp_pkg::BITS_BOOST : 6'd0)
                - (narrow ? dasp_pkg::BITS_NARROW : 6'd0);   // RULE17
   endfunction : data_bits

   wire [5:0] dbits = data_bits(req.boost, req.narrow);
   // Command frames decode the word; plain frames carry a no-operation
   wire is_write = req.word[dasp_pkg::DEV_WR_BIT] && !req.conv_only;      // RULE21
   wire is_read = !req.word[dasp_pkg::DEV_WR_BIT] && !req.conv_only;      // RULE19
   wire [2:0] addr = req.word[14:12];
   wire addr_ok = (addr == dasp_pkg::ADDR_PRIMARY) || (addr == dasp_pkg::ADDR_SECONDARY);
   wire data_frame = seq_r == 3'd1;     // Frame that returns data
   wire [5:0] res_len = req.one_lane ? {dbits[4:0], 1'b0} : dbits;         // RULE13 RULE14
   wire [5:0] rd_len = dasp_pkg::BITS_BASE + (req.crc_r ? dasp_pkg::BITS_CRC : 6'd0);
   wire [5:0] wr_len = dasp_pkg::BITS_BASE + (req.crc_w ? dasp_pkg::BITS_CRC : 6'd0); // RULE22
   wire [5:0] conv_len = res_len + (req.crc_r ? dasp_pkg::BITS_CRC : 6'd0); // RULE24
   // Register data only comes back for a known address
   wire reg_data = is_read && addr_ok && data_frame;                      // RULE27
   // Frames never drop below sixteen clocks
   wire [5:0] frame_len = is_write ? wr_len
                        : (reg_data ? rd_len : ((conv_len < 6'd16) ? 6'd16 : conv_len)); // RULE7

   // Order built from the control and command registers
   assign req = '{one_lane: ctrl_r[dasp_pkg::CTRL_ONE_LANE], boost: ctrl_r[dasp_pkg::CTRL_BOOST],
                  crc_r: ctrl_r[dasp_pkg::CTRL_CRC_R], crc_w: ctrl_r[dasp_pkg::CTRL_CRC_W],
                  narrow: ctrl_r[dasp_pkg::CTRL_NARROW], lowlat: ctrl_r[dasp_pkg::CTRL_LOWLAT],
                  conv_only: cmd_r[dasp_pkg::CMD_CONV], word: cmd_r[15:0]};

   // ------------------------------------------------------------------
   // Serial engine timing
   // ------------------------------------------------------------------
   wire half_done = half_r == 3'(dasp_pkg::SCLK_HALF - 1);
   wire last_bit = bit_r == nbits_r - 6'd1;
   wire rise = (state_r == S_LOW) && half_done;
   wire fall = (state_r == S_HIGH) && half_done;
   wire sample = rise;                  // Device shifts on rise; sample just before it
   // Low latency: wait out the conversion before the data frame
   wire conv_wait = req.lowlat && (seq_r == 3'd2) && req.conv_only;      // RULE18
   // Checksums restart while chip select is high, so each frame of a
   // two-frame order starts from a clean remainder
   wire crc_clr = cs_n;
   wire [5:0] crc_idx = bit_r;

   // Write checksum over the 16 command bits; stepped at each rise so the
   // last bit is in before the fall that sends the checksum
   dasp_crc u_crc_tx (.mclk(mclk), .nrst(nrst), .clr(crc_clr), .step(rise && bit_r < 6'd16),
                      .din(tx_r[23]), .idx(crc_idx), .crc(crc_tx));       // RULE25
   // Read checksum over the data received on the first output
   dasp_crc u_crc_rx (.mclk(mclk), .nrst(nrst), .clr(crc_clr),
                      .step(sample && bit_r < nbits_r - (req.crc_r ? 6'd8 : 6'd0)),
                      .din(sdo_a), .idx(crc_idx), .crc(crc_chk));

   // Next state of the frame sequencer
   // Every busy state is left on a count, so no frame can hang
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: if (busy_r) state_nxt = S_LOW;       // RULE6
         S_LOW: if (half_done) state_nxt = S_HIGH;
         S_HIGH: if (half_done) state_nxt = last_bit ? S_END : S_LOW;
         S_END: if (half_done) state_nxt = conv_wait ? S_WAIT : S_GAP;    // RULE11
         S_WAIT: if (conv_r == 8'(dasp_pkg::CONV_CYC)) state_nxt = S_GAP; // RULE8
         S_GAP: if (conv_r >= 8'(dasp_pkg::GAP_CYC)) state_nxt = (seq_r > 3'd1) ? S_LOW : S_IDLE;
         default: state_nxt = S_IDLE;
      endcase
   end

   // Frame counters
   // Half period timer, and gap or conversion wait timer
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_r <= S_IDLE;
         half_r <= 3'd0;
         conv_r <= 8'd0;
      end else begin
         state_r <= state_nxt;
         half_r <= (state_nxt != state_r || half_done) ? 3'd0 : half_r + 3'd1;
         conv_r <= (state_r == S_WAIT || state_r == S_GAP) && state_nxt == state_r
                   ? conv_r + 8'd1 : 8'd0;
      end
   end

   // Pins: frame ends with clock low, then chip select rises
   // Both come from flops fed by the next state, free of glitches
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cs_n <= 1'b1;
         sclk <= 1'b0;
      end else begin
         cs_n <= !(state_nxt == S_LOW || state_nxt == S_HIGH || state_nxt == S_END); // RULE12
         sclk <= state_nxt == S_HIGH;                                      // RULE10
      end
   end

   // Shift data out on falling edges, capture on rising edges
   // Set-up runs on the edge that drops chip select, so the first
   // command bit stands on the line well before the first rise
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         bit_r <= 6'd0;
         nbits_r <= 6'd16;
         tx_r <= 24'h0000_00;
         serial_command_input <= 1'b0;
         rx_a_r <= 44'h000_0000_0000;
         rx_b_r <= 18'h0_0000;
      end else if ((state_r == S_IDLE && busy_r) || (state_r == S_GAP && state_nxt == S_LOW)) begin
         bit_r <= 6'd0;
         nbits_r <= frame_len;
         rx_b_r <= 18'h0_0000;
         // A plain frame or the data frame of a read carries a no-operation
         tx_r <= (req.conv_only || (is_read && data_frame))
                 ? {dasp_pkg::NOP_WORD, 8'h00} : {req.word, 8'h00};       // RULE20
         serial_command_input <= req.conv_only ? 1'b0 : req.word[15];
      end else begin
         // Two flops of delay sit well inside the high half period
         if (sample) begin
            rx_a_r <= {rx_a_r[42:0], sdo_a};
         end
         // Line B keeps channel B's bits only
         if (sample && bit_r < dbits) begin
            rx_b_r <= {rx_b_r[16:0], sdo_b};                               // RULE15
         end
         if (fall) begin
            bit_r <= bit_r + 6'd1;
            // Append the write checksum after the command word
            tx_r <= (bit_r == 6'd15) ? {crc_tx, 16'h0000} : {tx_r[22:0], 1'b0}; // RULE26
            serial_command_input <= (bit_r == 6'd15) ? crc_tx[7] : tx_r[22];
         end
      end
   end

   // Collect results at the end of the data frame
   // Taken a full serial clock period after the last sample
   wire [43:0] rx_al = rx_a_r << (6'd44 - nbits_r);
   wire [5:0] sh_b = 6'd18 - dbits;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         res_a_r <= 18'h0_0000;
         res_b_r <= 18'h0_0000;
         crc_rx_r <= 8'h00;
         crc_ok_r <= 1'b0;
      end else if (state_r == S_END && half_done && data_frame) begin
         if (reg_data) begin
            res_a_r <= {2'b00, rx_al[43:28]};
         end else if (req.one_lane) begin
            // A first, then B, all on the first output
            res_a_r <= 18'(rx_al[43:26] >> sh_b);                          // RULE16
            res_b_r <= 18'((rx_al << dbits) >> (6'd26 + sh_b));
         end else begin
            res_a_r <= 18'(rx_al[43:26] >> sh_b);                          // RULE9
            // Line B was cleared at frame start and holds one result
            res_b_r <= rx_b_r;
         end
         crc_rx_r <= rx_a_r[7:0];
         crc_ok_r <= !req.crc_r || (rx_a_r[7:0] == crc_chk);               // RULE23
      end
   end

   // Order sequencing: reads and conversions take two frames
   // Orders are taken only while idle; software polls busy first
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         busy_r <= 1'b0;
         seq_r <= 3'd0;
      end else if (!busy_r && wb_cyc_i && wb_stb_i && wb_we_i && !ack_r
                   && wb_adr_i[7:0] == dasp_pkg::OFS_CMD && wb_sel_i[2]
                   && wb_dat_i[dasp_pkg::CMD_GO]) begin
         busy_r <= 1'b1;
         seq_r <= (wb_dat_i[dasp_pkg::CMD_CONV] || !wb_dat_i[15]) ? 3'd2 : 3'd1;
      end else if (state_r == S_END && half_done) begin
         seq_r <= seq_r - 3'd1;
         busy_r <= seq_r != 3'd1;
      end
   end

   // ------------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------------
   // Ack one cycle after the request, then low for a cycle, so a
   // held request is never taken twice
   wire wb_req = wb_cyc_i && wb_stb_i && !ack_r;
   // Status and results as software sees them
   assign rsp = '{res_a: res_a_r, res_b: res_b_r, crc_rx: crc_rx_r, crc_ok: crc_ok_r};
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ack_r <= 1'b0;
         ctrl_r <= 6'h00;
         cmd_r <= 18'h0_0000;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack_r <= wb_req;
         if (wb_req && wb_we_i && !busy_r) begin
            if (wb_adr_i[7:0] == dasp_pkg::OFS_CTRL && wb_sel_i[0]) ctrl_r <= wb_dat_i[5:0];
            // Reset codes travel in the command word chosen by software
            if (wb_adr_i[7:0] == dasp_pkg::OFS_CMD) cmd_r <= wb_dat_i[17:0]; // RULE1 RULE5
         end
         case (wb_adr_i[7:0])
            dasp_pkg::OFS_CTRL: wb_dat_o <= {26'h000_0000, ctrl_r};
            dasp_pkg::OFS_CMD: wb_dat_o <= {14'h0000, cmd_r};
            dasp_pkg::OFS_STAT: wb_dat_o <= {30'h0000_0000, rsp.crc_ok, busy_r};
            dasp_pkg::OFS_RES_A: wb_dat_o <= {14'h0000, rsp.res_a};
            dasp_pkg::OFS_RES_B: wb_dat_o <= {14'h0000, rsp.res_b};
            dasp_pkg::OFS_CRC: wb_dat_o <= {24'h00_0000, rsp.crc_rx};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end
   assign wb_ack_o = ack_r;

endmodule : dasp_host

/* File: verilog/dasp_pkg.sv */
/*
 * Package for the host-side serial controller of a dual simultaneous-sampling
 * converter: register offsets of the controller, device command layout,
 * setup-register fields, frame lengths and timing constants.
 * Assumes a 20 MHz system clock and a converter on a five-wire serial link.
 */
package dasp_pkg;

   // ------------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned SCLK_HALF = 4;            // Clocks per serial clock half period
   localparam int unsigned CONV_TIME_NS = 190;       // Conversion time, least
   localparam int unsigned CONV_CYC = (CONV_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned GAP_CYC = 2;              // Gap count; chip select stays high at least GAP_CYC + 1 clocks between frames

   // ------------------------------------------------------------------
   // Controller register offsets (byte addresses on Wishbone)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_RES_A = 8'h0C;
   localparam logic [7:0] OFS_RES_B = 8'h10;
   localparam logic [7:0] OFS_CRC = 8'h14;

   // Control register fields
   localparam int unsigned CTRL_ONE_LANE = 0;
   localparam int unsigned CTRL_BOOST = 1;
   localparam int unsigned CTRL_CRC_R = 2;
   localparam int unsigned CTRL_CRC_W = 3;
   localparam int unsigned CTRL_NARROW = 4;          // 14-bit variant
   localparam int unsigned CTRL_LOWLAT = 5;

   // Command register: [15:0] word, [16] plain conversion frame, [17] go
   localparam int unsigned CMD_CONV = 16;
   localparam int unsigned CMD_GO = 17;

   // ------------------------------------------------------------------
   // Device command layout
   // ------------------------------------------------------------------
   localparam int unsigned DEV_WR_BIT = 15;
   localparam int unsigned DEV_ADDR_LSB = 12;
   localparam logic [2:0] ADDR_PRIMARY = 3'h1;
   localparam logic [2:0] ADDR_SECONDARY = 3'h2;
   localparam logic [7:0] RESET_SOFT = 8'h3C;
   localparam logic [7:0] RESET_HARD = 8'hFF;
   localparam logic [15:0] NOP_WORD = 16'h0000;

   // ------------------------------------------------------------------
   // Frame lengths
   // ------------------------------------------------------------------
   localparam logic [5:0] BITS_BASE = 6'd16;
   localparam logic [5:0] BITS_BOOST = 6'd2;
   localparam logic [5:0] BITS_CRC = 6'd8;
   localparam logic [5:0] BITS_NARROW = 6'd2;
   localparam logic [7:0] CRC_POLY = 8'h07;          // x^8 + x^2 + x + 1

   // Orders from the register file to the serial engine
   typedef struct packed {
      logic one_lane;
      logic boost;
      logic crc_r;
      logic crc_w;
      logic narrow;
      logic lowlat;
      logic conv_only;
      logic [15:0] word;
   } dasp_req_t;

   // Results back from the serial engine
   typedef struct packed {
      logic [17:0] res_a;
      logic [17:0] res_b;
      logic [7:0] crc_rx;
      logic crc_ok;
   } dasp_rsp_t;

endpackage : dasp_pkg

/* File: verilog/dasp_sync.sv */
/*
 * Two-flop synchroniser for one level from outside the clock domain.
 * Assumes the input is a pin or another clock's signal.
 */
`timescale 1ns/10ps
module dasp_sync (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic d,
   output logic q
);
   logic meta_r;

   // Two stages; only the second is read outside
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         meta_r <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : dasp_sync
